/* core/sma_consts.svh */
// constants for the special-function-register math accelerator
//
// Behaviour
// - operation chosen by order of operand writes
// - divide: A bytes LSB first, then B
// - divide busy 9 or 6 machine cycles
// - divide results: quotient MSB first, remainder
// - divide takes 36 or 24 clocks
// - multiply: B low/high, then A low/high
// - multiply busy 6 cycles, product MSB first
// - shift: load A, set controls, 9 cycles
// - shift result read from A MSB first
// - normalize: load A, write count zero
// - normalize gives mantissa and 5-bit exponent
// - unrelated accesses leave sequence undisturbed
// - out-of-order access corrupts; clearing busy restarts
// - multiply/divide results added to 40-bit accumulator
// - accumulator: five writes LSB, reads MSB first
`ifndef SMA_CONSTS_SVH
`define SMA_CONSTS_SVH

// -----------------------------------------------------------------
// device register addresses on the accelerator port
// -----------------------------------------------------------------
`define SMA_ADR_OPA        3'h0
`define SMA_ADR_OPB        3'h1
`define SMA_ADR_ACC        3'h2
`define SMA_ADR_CNT        3'h3
`define SMA_ADR_STAT       3'h4

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define SMA_STAT_BUSY_BIT  7
`define SMA_STAT_DIR_BIT   6
`define SMA_ACC_BYTES      3'h5
`define SMA_ACC_RST        40'h00_0000_0000

// -----------------------------------------------------------------
// timing: clock periods per machine cycle and per operation
// -----------------------------------------------------------------
`define SMA_MC_CLKS        4
`define SMA_DIV32_MC       9
`define SMA_DIV16_MC       6
`define SMA_MUL_MC         6
`define SMA_SHIFT_MC       9
`define SMA_NORM_MC        9
`define SMA_DIV32_CYC      6'(`SMA_DIV32_MC * `SMA_MC_CLKS)
`define SMA_DIV16_CYC      6'(`SMA_DIV16_MC * `SMA_MC_CLKS)
`define SMA_MUL_CYC        6'(`SMA_MUL_MC * `SMA_MC_CLKS)
`define SMA_SHIFT_CYC      6'(`SMA_SHIFT_MC * `SMA_MC_CLKS)
`define SMA_NORM_CYC       6'(`SMA_NORM_MC * `SMA_MC_CLKS)

// -----------------------------------------------------------------
// host wishbone map and command fields
// -----------------------------------------------------------------
`define SMA_WB_CMD         4'h0
`define SMA_WB_STAT        4'h4
`define SMA_CMD_RD_BIT     16
`define SMA_WB_PEND_BIT    8
`define SMA_WB_BUSY_BIT    9

`endif

/* core/sma_pkg.sv */
// types shared by both ends of the math accelerator
package sma_pkg;

   // -----------------------------------------------------------------
   // sequencer states of the accelerator
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      IDLE,    // nothing loaded
      LOAD_A,  // operand a written first: divide, shift or normalize
      LOAD_B,  // operand b written first: multiply
      RUN,     // operation in progress, busy set
      DONE,    // results ready for reading
      ERR      // sequence corrupted, waits for busy clear
   } sma_state_e;

   // -----------------------------------------------------------------
   // whole device state
   // -----------------------------------------------------------------
   typedef struct packed {
      sma_state_e  st;     // sequencer state
      logic [2:0]  a_cnt;  // operand a bytes written
      logic [1:0]  b_cnt;  // operand b bytes written
      logic [31:0] opa;    // operand a, bytes shift in from the top
      logic [15:0] opb;    // operand b
      logic [31:0] res;    // main result, read msb first
      logic [15:0] rem;    // remainder
      logic [39:0] acc;    // running accumulator
      logic [2:0]  acc_ri; // accumulator read index
      logic [4:0]  cnt;    // shift count or exponent
      logic        dir;    // shift direction, 1 = right
      logic        busy;   // busy flag
      logic [5:0]  wait_c; // clocks left in run
      logic [7:0]  rdata;  // read data to port
   } sma_dev_s;

   // -----------------------------------------------------------------
   // whole host state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        ack;    // wishbone ack
      logic [31:0] dat;    // wishbone read data
      logic [2:0]  addr;   // port address
      logic        wr;     // port write strobe
      logic        rd;     // port read strobe
      logic [7:0]  wdata;  // port write data
      logic        cap;    // capture read data this cycle
      logic [7:0]  last;   // last byte read
      logic        pend;   // access in flight
   } sma_host_s;

endpackage : sma_pkg

/* core/sma_if.sv */
// register port between the controller and the math accelerator
interface sma_if;
   logic [2:0] addr;            // register select
   logic       wr;              // write strobe, one cycle
   logic       rd;              // read strobe, one cycle
   logic [7:0] wdata;           // write data
   logic [7:0] rdata;           // read data, valid cycle after rd
   logic       accel_busy_flag; // busy flag level

   modport dev  (input addr, wr, rd, wdata, output rdata, accel_busy_flag);
   modport host (output addr, wr, rd, wdata, input rdata, accel_busy_flag);
endinterface : sma_if

/* core/sma_device.sv */
// math accelerator: operand sequencer, arithmetic and accumulator
`include "sma_consts.svh"

module sma_device (
   input  wire logic clk_i, // core clock
   input  wire logic rst_i, // synchronous reset, high
   sma_if.dev        port   // register port
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sma_pkg::sma_dev_s q;      // registered state
   sma_pkg::sma_dev_s next_q; // next state

   // leading zero count for normalize; zero input reports zero
   function automatic logic [4:0] sma_lz(input logic [31:0] v);
      logic [4:0] n;
      logic       hit;
      n   = 5'h00;
      hit = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (!hit && v[i]) begin
            hit = 1'b1;
            n   = 5'(31 - i);
         end
      end
      return n;
   endfunction : sma_lz

   // -----------------------------------------------------------------
   // arithmetic, computed at launch; the wait only models latency
   // -----------------------------------------------------------------
   logic [31:0] dvd;     // dividend, 16 or 32 bits
   logic [31:0] quo;     // quotient
   logic [15:0] rmd;     // remainder
   logic [15:0] dvs;     // divisor as it stands at the launch write
   logic [31:0] prod;    // product
   logic [31:0] shl;     // shifted value
   logic [4:0]  lz;      // normalize shift
   logic        wr_a;    // decoded strobes
   logic        wr_b;
   logic        wr_c;
   logic        rd_a;
   logic        rd_b;
   logic        rd_c;
   logic        acc_a;   // any access to a, b or c

   always_comb begin
      // 16-bit dividend sits in the top half after two writes
      dvd  = (q.a_cnt == 3'h2) ? {16'h0000, q.opa[31:16]} : q.opa;
      // divide by zero gives all ones and keeps the dividend low half
      // divisor high byte is still on the port at the launch write
      dvs  = {port.wdata, q.opb[15:8]};
      quo  = (dvs == 16'h0000) ? 32'hffff_ffff : dvd / {16'h0000, dvs};
      rmd  = (dvs == 16'h0000) ? dvd[15:0] : 16'(dvd % {16'h0000, dvs});
      // multiplicand high byte likewise arrives with the launch write
      prod = {16'h0000, port.wdata, q.opa[31:24]} * {16'h0000, q.opb};
      shl  = q.dir ? (q.opa >> port.wdata[4:0]) : (q.opa << port.wdata[4:0]);
      lz   = sma_lz(q.opa);
   end

   // address decode; other addresses fall through untouched
   always_comb begin
      wr_a   = port.wr && port.addr == `SMA_ADR_OPA;
      wr_b   = port.wr && port.addr == `SMA_ADR_OPB;
      wr_c   = port.wr && port.addr == `SMA_ADR_ACC;
      rd_a   = port.rd && port.addr == `SMA_ADR_OPA;
      rd_b   = port.rd && port.addr == `SMA_ADR_OPB;
      rd_c   = port.rd && port.addr == `SMA_ADR_ACC;
      acc_a  = wr_a || wr_b || wr_c || rd_a || rd_b || rd_c;
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_q = q;

      // register reads: data shows the cycle after the strobe
      if (port.rd) begin
         unique case (port.addr)
            `SMA_ADR_OPA:  next_q.rdata = q.res[31:24];          // msb first
            `SMA_ADR_OPB:  next_q.rdata = q.rem[15:8];           // high then low
            `SMA_ADR_ACC:  next_q.rdata = q.acc[8 * (4 - q.acc_ri) +: 8];
            `SMA_ADR_CNT:  next_q.rdata = {3'h0, q.cnt};         // exponent
            `SMA_ADR_STAT: next_q.rdata = {q.busy, q.dir, 6'h00};
            default:       next_q.rdata = 8'h00;                 // unmapped reads zero
         endcase
      end

      // control register write: direction, and busy clear restarts
      if (port.wr && port.addr == `SMA_ADR_STAT) begin
         next_q.dir = port.wdata[`SMA_STAT_DIR_BIT];
      end

      unique case (q.st)
         // accepting a new sequence; results may still be read
         sma_pkg::IDLE, sma_pkg::DONE: begin
            if (rd_a) begin
               next_q.res = {q.res[23:0], 8'h00}; // step to next byte
            end
            if (rd_b) begin
               next_q.rem = {q.rem[7:0], 8'h00};
            end
            if (rd_c) begin
               next_q.acc_ri = (q.acc_ri == `SMA_ACC_BYTES - 3'h1) ? 3'h0 : q.acc_ri + 3'h1;
            end
            if (wr_c) begin
               next_q.acc = {port.wdata, q.acc[39:8]}; // five writes lsb first
            end
            if (wr_a) begin
               // a first selects divide, shift or normalize
               next_q.st    = sma_pkg::LOAD_A;
               next_q.a_cnt = 3'h1;
               next_q.b_cnt = 2'h0;
               next_q.opa   = {port.wdata, q.opa[31:8]};
            end else if (wr_b) begin
               // b first selects multiply
               next_q.st    = sma_pkg::LOAD_B;
               next_q.b_cnt = 2'h1;
               next_q.a_cnt = 3'h0;
               next_q.opb   = {port.wdata, q.opb[15:8]};
            end
         end

         // dividend bytes, then divisor, or count for shift
         sma_pkg::LOAD_A: begin
            if (wr_a && q.a_cnt < 3'h4 && q.b_cnt == 2'h0) begin
               next_q.a_cnt = q.a_cnt + 3'h1;
               next_q.opa   = {port.wdata, q.opa[31:8]}; // lsb first
            end else if (wr_b && (q.a_cnt == 3'h2 || q.a_cnt == 3'h4)) begin
               next_q.b_cnt = q.b_cnt + 2'h1;
               next_q.opb   = {port.wdata, q.opb[15:8]};
               if (q.b_cnt == 2'h1) begin
                  // divisor high byte launches the divide
                  next_q.st     = sma_pkg::RUN;
                  next_q.busy   = 1'b1;
                  next_q.wait_c = (q.a_cnt == 3'h4) ? `SMA_DIV32_CYC
                                                    : `SMA_DIV16_CYC;
                  // 16-bit quotient is left aligned so two reads suffice
                  next_q.res    = (q.a_cnt == 3'h4) ? quo : {quo[15:0], 16'h0000};
                  next_q.rem    = rmd;
                  next_q.acc    = q.acc + {8'h00, quo};
               end
            end else if (acc_a) begin
               next_q.st   = sma_pkg::ERR; // out of order
               next_q.busy = 1'b1;
            end else if (port.wr && port.addr == `SMA_ADR_CNT && q.a_cnt == 3'h4
                         && q.b_cnt == 2'h0) begin
               next_q.st   = sma_pkg::RUN;
               next_q.busy = 1'b1;
               if (port.wdata[4:0] == 5'h00) begin
                  // zero count means normalize
                  next_q.res    = q.opa << lz;
                  next_q.cnt    = lz;
                  next_q.wait_c = `SMA_NORM_CYC;
               end else begin
                  next_q.res    = shl;
                  next_q.cnt    = port.wdata[4:0];
                  next_q.wait_c = `SMA_SHIFT_CYC;
               end
            end
         end

         // multiplier bytes then multiplicand bytes
         sma_pkg::LOAD_B: begin
            if (wr_b && q.b_cnt == 2'h1 && q.a_cnt == 3'h0) begin
               next_q.b_cnt = 2'h2;
               next_q.opb   = {port.wdata, q.opb[15:8]};
            end else if (wr_a && q.b_cnt == 2'h2) begin
               next_q.a_cnt = q.a_cnt + 3'h1;
               next_q.opa   = {port.wdata, q.opa[31:8]};
               if (q.a_cnt == 3'h1) begin
                  // multiplicand high byte launches
                  next_q.st     = sma_pkg::RUN;
                  next_q.busy   = 1'b1;
                  next_q.wait_c = `SMA_MUL_CYC;
                  next_q.res    = prod;
                  next_q.acc    = q.acc + {8'h00, prod};
               end
            end else if (acc_a) begin
               next_q.st   = sma_pkg::ERR;
               next_q.busy = 1'b1;
            end
         end

         // latency countdown; busy readable all along
         sma_pkg::RUN: begin
            if (acc_a) begin
               next_q.st   = sma_pkg::ERR;
               next_q.busy = 1'b1;
            end else if (q.wait_c == 6'h01) begin
               next_q.st   = sma_pkg::DONE;
               next_q.busy = 1'b0;
            end else begin
               next_q.wait_c = q.wait_c - 6'h01;
            end
         end

         // stuck until software clears busy
         sma_pkg::ERR: begin
            next_q.busy = 1'b1;
         end
      endcase

      // clearing busy returns to idle from anywhere
      if (port.wr && port.addr == `SMA_ADR_STAT && !port.wdata[`SMA_STAT_BUSY_BIT]) begin
         next_q.st     = sma_pkg::IDLE;
         next_q.busy   = 1'b0;
         next_q.a_cnt  = 3'h0;
         next_q.b_cnt  = 2'h0;
         next_q.acc_ri = 3'h0;
         next_q.wait_c = 6'h00;
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{st: sma_pkg::IDLE, acc: `SMA_ACC_RST, default: '0};
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flops
   assign port.rdata           = q.rdata;
   assign port.accel_busy_flag = q.busy;

endmodule : sma_device

/* core/sma_host.sv */
// controller end: wishbone slave that drives the accelerator port
`include "sma_consts.svh"

module sma_host (
   input  wire logic        clk_i,    // core clock
   input  wire logic        rst_i,    // synchronous reset, high
   input  wire logic        wb_cyc_i, // wishbone cycle
   input  wire logic        wb_stb_i, // wishbone strobe
   input  wire logic        wb_we_i,  // wishbone write
   input  wire logic [3:0]  wb_adr_i, // byte address
   input  wire logic [31:0] wb_dat_i, // write data
   input  wire logic [3:0]  wb_sel_i, // byte lanes
   output logic      [31:0] wb_dat_o, // read data
   output logic             wb_ack_o, // acknowledge
   sma_if.host              port      // accelerator port
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   sma_pkg::sma_host_s q;      // registered state
   sma_pkg::sma_host_s next_q; // next state
   logic               req;    // new wishbone request

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      next_q     = q;
      next_q.ack = 1'b0;
      next_q.wr  = 1'b0;
      next_q.rd  = 1'b0;
      next_q.cap = q.rd;       // device answers one cycle after rd
      req        = wb_cyc_i && wb_stb_i && !q.ack;
      if (q.wr) begin
         next_q.pend = 1'b0;
      end
      if (q.cap) begin
         next_q.last = port.rdata;
         next_q.pend = 1'b0;
      end
      if (req) begin
         next_q.ack = 1'b1;    // every address answers, unmapped too
         next_q.dat = 32'h0000_0000;
         if (wb_we_i) begin
            // one port access per command; dropped while one is in flight
            if (wb_adr_i == `SMA_WB_CMD && wb_sel_i[0] && !q.pend) begin
               next_q.addr  = wb_dat_i[10:8];
               next_q.wdata = wb_dat_i[7:0];
               next_q.rd    = wb_dat_i[`SMA_CMD_RD_BIT];
               next_q.wr    = !wb_dat_i[`SMA_CMD_RD_BIT]; // order is software's
               next_q.pend  = 1'b1;
            end
         end else if (wb_adr_i == `SMA_WB_STAT) begin
            // busy mirror lets software poll completion
            next_q.dat = {22'h00_0000, port.accel_busy_flag, q.pend, q.last};
         end
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // outputs straight from flops
   assign wb_ack_o   = q.ack;
   assign wb_dat_o   = q.dat;
   assign port.addr  = q.addr;
   assign port.wr    = q.wr;
   assign port.rd    = q.rd;
   assign port.wdata = q.wdata;

endmodule : sma_host

/* verif/sma_properties.sv */
// concurrent checks on the accelerator register port
module sma_port_checker (
   input wire logic       clk_i,           // core clock
   input wire logic       rst_i,           // synchronous reset, high
   input wire logic [2:0] addr,            // register select
   input wire logic       wr,              // write strobe
   input wire logic       rd,              // read strobe
   input wire logic [7:0] wdata,           // write data
   input wire logic [7:0] rdata,           // read data
   input wire logic       accel_busy_flag  // busy level
);
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // helper logic
   // -----------------------------------------------------------------
   logic [15:0] busy_len; // cycles busy has stood so far
   logic        clr;      // status write that drops busy

   assign clr = wr && addr == 3'h4 && !wdata[7];

   // wide counter: a stuck busy after a bad sequence must not wrap early
   always_ff @(posedge clk_i) begin
      if (rst_i || !accel_busy_flag) busy_len <= 16'h0;
      else busy_len <= busy_len + 16'h1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_busy_rise_write: assert property ($rose(accel_busy_flag) |-> $past(wr))
      else $error("busy rose without a port write");
   a_busy_launch_reg: assert property ($rose(accel_busy_flag) |-> $past(addr) < 3'h4)
      else $error("busy rose on a write outside the operand set");
   a_busy_hold_min: assert property (accel_busy_flag && !clr && busy_len < 16'h17 |=> accel_busy_flag)
      else $error("busy dropped before 24 clocks");
   a_busy_fall_len: assert property ($fell(accel_busy_flag) |->
      busy_len == 16'h18 || busy_len == 16'h24 || $past(clr))
      else $error("busy length neither 24 nor 36 clocks");
   a_busy_clear_now: assert property (clr |=> !accel_busy_flag)
      else $error("status clear did not drop busy");
   a_rdata_by_read: assert property ($changed(rdata) |-> $past(rd))
      else $error("read data moved without a read");
   a_strobe_single: assert property (wr || rd |=> !(wr || rd))
      else $error("port strobe longer than one cycle");
   a_no_dual_strobe: assert property (!(wr && rd))
      else $error("read and write strobes together");
endmodule : sma_port_checker

/* verif/sfr_math_accelerator_tb_top.sv */
// self-checking bench: host and device joined over the register port
module sfr_math_accelerator_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i, rst_i, cyc, stb, we; // clock, reset, bus controls
   logic [3:0]  adr, sel;                   // bus address and lanes
   logic [31:0] wdat, rdat;                 // bus data
   logic        ack;                        // bus acknowledge
   logic [39:0] acc_exp = 40'h0;            // expected accumulator
   logic [7:0]  expq[$];                    // expected read bytes
   logic        rd_q = 1'b0;                // read strobe, one cycle late
   integer      seed = 32'h4993;            // fixed seed
   int          n_mismatch = 0, samples_checked = 0, cycles = 0;

   sma_if port_if ();
   sma_host u_sma_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
      .wb_ack_o(ack), .port(port_if));
   sma_device u_sma_device (.clk_i(clk_i), .rst_i(rst_i), .port(port_if));
   sma_port_checker u_sma_port_checker (.clk_i(clk_i), .rst_i(rst_i), .addr(port_if.addr),
      .wr(port_if.wr), .rd(port_if.rd), .wdata(port_if.wdata), .rdata(port_if.rdata),
      .accel_busy_flag(port_if.accel_busy_flag));

   // -----------------------------------------------------------------
   // clock, timeout and verdict
   // -----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // a hang anywhere ends here as a failure
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // read data is settled the cycle after the strobe; oldest note first
   always @(posedge clk_i) begin
      if (rd_q === 1'b1) begin
         if (expq.size() == 0) chk("rdata_extra", 40'h1, 40'h0);
         else chk("rdata", port_if.rdata, expq.pop_front());
      end
      rd_q <= port_if.rd;
   end

   // -----------------------------------------------------------------
   // bus and port tasks
   // -----------------------------------------------------------------
   // classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // no count of our own: only the bench timeout ends a wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // poll status until the port access is no longer pending
   task automatic idle_wait();
      logic [31:0] r;
      do begin
         wb(1'b0, 4'h4, 32'h0, r);
      end while (r[8] !== 1'b0);
   endtask : idle_wait

   task automatic pw(input logic [2:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, 4'h0, {21'h0, a, d}, r);
      idle_wait();
   endtask : pw

   task automatic pr(input logic [2:0] a, input logic [7:0] e);
      logic [31:0] r;
      expq.push_back(e);
      wb(1'b1, 4'h0, {15'h0, 1'b1, 5'h0, a, 8'h00}, r);
      idle_wait();
   endtask : pr

   task automatic busy_wait();
      logic [31:0] r;
      do begin
         wb(1'b0, 4'h4, 32'h0, r);
      end while (r[9] !== 1'b0);
   endtask : busy_wait

   // operand a loads lsb first, with an unmapped write in between
   task automatic wr_a(input logic [31:0] v, input int nb);
      for (int i = 0; i < nb; i++) begin
         pw(3'h0, v[8*i +: 8]);
         pw(3'h5, 8'hff);
      end
   endtask : wr_a

   task automatic rd_bytes(input logic [2:0] a, input logic [39:0] v, input int nb);
      for (int i = nb - 1; i >= 0; i--) pr(a, v[8*i +: 8]);
   endtask : rd_bytes

   // -----------------------------------------------------------------
   // operations
   // -----------------------------------------------------------------
   task automatic do_div(input int nb);
      logic [31:0] a, r;
      logic [15:0] b;
      a = $random(seed);
      if (nb == 2) a[31:16] = 16'h0;
      b = 16'($random(seed)) | 16'h1;
      wr_a(a, nb);
      pw(3'h1, b[7:0]);
      pw(3'h1, b[15:8]);
      wb(1'b0, 4'h4, 32'h0, r);
      chk("busy_set", {39'h0, r[9]}, 40'h1);
      busy_wait();
      rd_bytes(3'h0, {8'h0, a / b}, nb);
      rd_bytes(3'h1, {24'h0, a % b}, 2);
      acc_exp = acc_exp + {8'h0, a / b};
   endtask : do_div

   task automatic do_mul();
      logic [15:0] x, b;
      logic [31:0] p;
      x = 16'($random(seed));
      b = 16'($random(seed));
      pw(3'h1, b[7:0]);
      pw(3'h1, b[15:8]);
      pw(3'h0, x[7:0]);
      pw(3'h0, x[15:8]);
      busy_wait();
      p = {16'h0, x} * {16'h0, b};
      rd_bytes(3'h0, {8'h0, p}, 4);
      acc_exp = acc_exp + {8'h0, p};
   endtask : do_mul

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin : main
      logic [31:0] a, r;
      logic [4:0]  n;
      int          lz;
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hf;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      do_div(4);
      do_div(2);
      do_mul();
      rd_bytes(3'h2, acc_exp, 5);
      acc_exp = {8'($random(seed)), 32'($random(seed))};
      for (int i = 0; i < 5; i++) pw(3'h2, acc_exp[8*i +: 8]);
      rd_bytes(3'h2, acc_exp, 5);
      // shift left then right; direction set before the load
      for (int d = 0; d < 2; d++) begin
         pw(3'h4, {1'b0, d[0], 6'h0});
         a = $random(seed);
         n = 5'($random(seed)) | 5'h1;
         wr_a(a, 4);
         wb(1'b0, 4'h8, 32'h0, r);
         chk("unmapped", {8'h0, r}, 40'h0);
         pw(3'h3, {3'h0, n});
         busy_wait();
         rd_bytes(3'h0, {8'h0, (d == 1) ? a >> n : a << n}, 4);
      end
      // normalize: leading zeros become the exponent
      a = (32'($random(seed)) | 32'h1) >> (5'($random(seed)));
      lz = 0;
      while (a[31 - lz] == 1'b0) lz++;
      wr_a(a, 4);
      pw(3'h3, 8'h00);
      busy_wait();
      rd_bytes(3'h0, {8'h0, a << lz}, 4);
      pr(3'h3, 8'(lz));
      // accumulator touched mid-load: stuck busy until cleared
      pw(3'h0, 8'h12);
      pw(3'h2, 8'h34);
      repeat (50) @(posedge clk_i);
      wb(1'b0, 4'h4, 32'h0, r);
      chk("busy_stuck", {39'h0, r[9]}, 40'h1);
      pw(3'h4, 8'h00);
      wb(1'b0, 4'h4, 32'h0, r);
      chk("busy_freed", {39'h0, r[9]}, 40'h0);
      do_mul();
      repeat (4) @(posedge clk_i);
      chk("queue_left", 40'(expq.size()), 40'h0);
      print_verdict();
   end
endmodule : sfr_math_accelerator_tb_top
